//--- hw/dtc_trigger.sv
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "dtc_regs.svh"
module dtc_trigger (
  // clock and reset
  input  logic                 clk_i,
  input  logic                 rst_i,
  // wishbone slave
  input  dtc_pkg::dtc_wb_req_t wb_i,
  output logic                 ack_o,
  output logic [31:0]          dat_o,
  // watched core bus
  input  dtc_pkg::dtc_core_t   core_i,
  // trigger results
  output logic                 trig_o,
  output logic                 brk_req_o,
  output logic                 armed_o
);
  import dtc_pkg::*;

  dtc_state_t  st_q;
  dtc_state_t  st_d;
  logic [15:0] mem_rdata;
  logic [15:0] mem_wdata;
  logic [15:0] item_d;
  logic [15:0] bdat;
  logic [31:0] rd_d;
  logic        mem_we;
  logic        req;
  logic        wr;
  logic        c1_wr;
  logic        arm_wr;
  logic        a_f;
  logic        a_t;
  logic        b_f;
  logic        b_t;
  logic        c_f;
  logic        c_t;
  logic        b_eq;
  logic        a_sel;
  logic        b_sel;
  logic        bm;
  logic        eval;
  logic        det;
  logic        evonly;
  logic        begin_eff;
  logic        set_a;
  logic        set_b;
  logic        set_c;
  logic        trig_c;
  logic        store_ok;
  logic        item_v;

  // address match with optional page bits
  function automatic logic addr_hit(input dtc_cmp_t c, input logic [15:0] a,
                                    input logic [5:0] x);
    addr_hit = (a == c.addr) && (!c.page_selector[`DTC_PSEL_EXT_BIT] || (x == c.ext));
  endfunction

  // read/write qualification
  function automatic logic rw_ok(input logic en, input logic sel, input logic rw);
    rw_ok = !en || (rw == sel);
  endfunction

  // byte-lane write of a comparator word
  function automatic dtc_cmp_t cmp_wr(input dtc_cmp_t c, input dtc_wb_req_t w);
    dtc_cmp_t n;
    n = c;
    if (w.sel[`DTC_LANE0]) begin
      n[`DTC_BYTE0] = w.dat[`DTC_BYTE0];
    end
    if (w.sel[`DTC_LANE1]) begin
      n[`DTC_BYTE1] = w.dat[`DTC_BYTE1];
    end
    if (w.sel[`DTC_LANE2]) begin
      n[`DTC_BYTE2] = w.dat[`DTC_BYTE2];
    end
    cmp_wr = n;
  endfunction

  // trace storage
  dtc_trace_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (st_q.wp),
    .wdata_i (mem_wdata),
    .raddr_i (st_q.rp),
    .rdata_o (mem_rdata)
  );

  // next-state logic
  always_comb begin
    st_d   = st_q;
    req    = wb_i.cyc && wb_i.stb && !st_q.ack;
    wr     = req && wb_i.we;
    c1_wr  = wr && (wb_i.adr == `DTC_OFS_CTRL1) && wb_i.sel[`DTC_LANE0];
    arm_wr = c1_wr && wb_i.dat[`DTC_C1_EN] && wb_i.dat[`DTC_C1_ARM]
             && !st_q.c2.legacy_breakpoint_mode;

    a_f  = core_i.valid && addr_hit(st_q.ca, core_i.addr, core_i.xaddr)
           && rw_ok(st_q.c2.comparator_a_rw_enable, st_q.c2.comparator_a_rw_select,
                    core_i.rw);
    bdat = core_i.rw ? core_i.rdata : core_i.wdata;
    b_eq = (bdat == st_q.cb.addr);
    b_f  = core_i.valid && addr_hit(st_q.cb, core_i.addr, core_i.xaddr)
           && rw_ok(st_q.c2.comparator_b_rw_enable, st_q.c2.comparator_b_rw_select,
                    core_i.rw);
    c_t  = core_i.exec && st_q.c2.third_breakpoint_enable
           && st_q.c2.third_breakpoint_tag_select
           && addr_hit(st_q.cc, core_i.exec_addr, core_i.xaddr);
    c_f  = core_i.valid && st_q.c2.third_breakpoint_enable
           && !st_q.c2.third_breakpoint_tag_select
           && addr_hit(st_q.cc, core_i.addr, core_i.xaddr)
           && rw_ok(st_q.c2.third_breakpoint_rw_enable,
                    st_q.c2.third_breakpoint_rw_select, core_i.rw);
    // tagged path has no rw check
    a_t  = core_i.exec && addr_hit(st_q.ca, core_i.exec_addr, core_i.xaddr) && !c_t;
    b_t  = core_i.exec && addr_hit(st_q.cb, core_i.exec_addr, core_i.xaddr) && !c_t;
    a_sel = st_q.c1.trigger_select ? a_t : a_f;
    b_sel = st_q.c1.trigger_select ? b_t : b_f;

    det       = (st_q.c1.capture == `DTC_CAP_DETAIL);
    evonly    = !det && ((st_q.c1.mode == `DTC_M_EVB) || (st_q.c1.mode == `DTC_M_AEVB));
    begin_eff = evonly || st_q.c1.begin_trig;
    bm        = (det || (st_q.c1.mode == `DTC_M_ATHB)) ? b_sel : b_f;
    eval      = st_q.armed && st_q.c1.trace_mode_enable && !st_q.c2.legacy_breakpoint_mode;

    set_a  = 1'b0;
    set_b  = 1'b0;
    trig_c = 1'b0;
    unique case (st_q.c1.mode)
      `DTC_M_AONLY: begin
        set_a  = a_sel;
        trig_c = a_sel;
      end
      `DTC_M_AORB: begin
        set_a  = a_sel;
        set_b  = b_sel;
        trig_c = a_sel || b_sel;
      end
      `DTC_M_ATHB, `DTC_M_AEVB: begin
        set_a  = a_sel;
        set_b  = bm && st_q.seq;
        trig_c = bm && st_q.seq;
      end
      `DTC_M_EVB: begin
        set_b  = bm;
        trig_c = bm;
      end
      `DTC_M_AANDB: begin
        if (st_q.c1.trigger_select) begin
          set_a  = a_t;
          trig_c = a_t;
        end else begin
          set_a  = a_f && b_eq;
          set_b  = a_f && b_eq;
          trig_c = a_f && b_eq;
        end
      end
      `DTC_M_ANOTB: begin
        if (st_q.c1.trigger_select) begin
          set_a  = a_t;
          trig_c = a_t;
        end else begin
          set_a  = a_f && !b_eq;
          set_b  = a_f && !b_eq;
          trig_c = a_f && !b_eq;
        end
      end
      default: ;
    endcase
    set_a  = set_a && eval;
    set_b  = set_b && eval;
    trig_c = trig_c && eval;
    set_c  = (c_t || c_f) && (eval || st_q.c2.legacy_breakpoint_mode);
    if (set_a) begin
      st_d.seq = 1'b1;
    end

    item_v = core_i.cof;
    item_d = core_i.addr;
    if (det) begin
      item_v = core_i.valid && !core_i.fetch && !core_i.free;
    end else if (evonly) begin
      item_v = set_b;
      item_d = bdat;
    end

    unique case (st_q.ts)
      TS_ARMED: store_ok = eval && (!begin_eff || trig_c);
      TS_POST:  store_ok = eval;
      default:  store_ok = 1'b0;
    endcase

    // trace write, detail data follows address
    mem_we    = st_q.pend || (item_v && store_ok);
    mem_wdata = st_q.pend ? st_q.pdat : item_d;
    st_d.pend = !st_q.pend && item_v && store_ok && det;
    st_d.pdat = bdat;
    if (mem_we) begin
      st_d.wp = st_q.wp + `DTC_PTR_ONE;
      if (st_q.cnt != `DTC_DEPTH) begin
        st_d.cnt = st_q.cnt + `DTC_CNT_ONE;
      end
    end

    // arm clears at an end trigger, or at full after a begin trigger
    unique case (st_q.ts)
      TS_IDLE: ;
      TS_ARMED: begin
        if (trig_c) begin
          st_d.ts = begin_eff ? TS_POST : TS_IDLE;
        end
      end
      TS_POST: begin
        if (mem_we && (st_q.cnt == `DTC_LAST)) begin
          st_d.ts = TS_IDLE;
        end
      end
      default: st_d.ts = TS_IDLE;
    endcase
    if (c1_wr && !arm_wr) begin
      st_d.ts = TS_IDLE;
    end
    if ((st_d.ts == TS_IDLE) && st_q.armed && (st_d.cnt == `DTC_DEPTH)) begin
      st_d.rp = st_d.wp;
    end

    if (arm_wr) begin
      st_d.ts   = TS_ARMED;
      st_d.fa   = 1'b0;
      st_d.fb   = 1'b0;
      st_d.fc   = 1'b0;
      st_d.trg  = 1'b0;
      st_d.seq  = 1'b0;
      st_d.cnt  = '0;
      st_d.wp   = '0;
      st_d.rp   = '0;
      st_d.pend = 1'b0;
    end
    if (set_a) begin
      st_d.fa = 1'b1;
    end
    if (set_b) begin
      st_d.fb = 1'b1;
    end
    if (set_c) begin
      st_d.fc = 1'b1;
    end
    if (trig_c) begin
      st_d.trg = 1'b1;
    end
    st_d.armed = (st_d.ts != TS_IDLE);

    st_d.trig = trig_c;
    st_d.brk  = (trig_c && st_q.c1.brk_en)
                || (st_q.c2.legacy_breakpoint_mode && (c_t || c_f));

    // register writes
    if (wr) begin
      case (wb_i.adr)
        `DTC_OFS_CTRL1: begin
          if (wb_i.sel[`DTC_LANE0]) begin
            st_d.c1.trace_mode_enable = wb_i.dat[`DTC_C1_EN];
            st_d.c1.trigger_select    = wb_i.dat[`DTC_C1_TRIGGER_SELECT];
            st_d.c1.begin_trig        = wb_i.dat[`DTC_C1_BEGIN];
            st_d.c1.capture           = wb_i.dat[`DTC_C1_CAP];
            st_d.c1.brk_en            = wb_i.dat[`DTC_C1_BRK];
          end
          if (wb_i.sel[`DTC_LANE1]) begin
            st_d.c1.mode = wb_i.dat[`DTC_C1_MODE];
          end
        end
        `DTC_OFS_CTRL2: begin
          if (wb_i.sel[`DTC_LANE0]) begin
            st_d.c2.legacy_breakpoint_mode      = wb_i.dat[`DTC_C2_LEG];
            st_d.c2.third_breakpoint_enable     = wb_i.dat[`DTC_C2_CEN];
            st_d.c2.third_breakpoint_tag_select = wb_i.dat[`DTC_C2_CTAG];
            st_d.c2.third_breakpoint_rw_enable  = wb_i.dat[`DTC_C2_CRWEN];
            st_d.c2.third_breakpoint_rw_select  = wb_i.dat[`DTC_C2_CRW];
            st_d.c2.comparator_a_rw_enable      = wb_i.dat[`DTC_C2_ARWEN];
            st_d.c2.comparator_a_rw_select      = wb_i.dat[`DTC_C2_ARW];
            st_d.c2.comparator_b_rw_enable      = wb_i.dat[`DTC_C2_BRWEN];
          end
          if (wb_i.sel[`DTC_LANE1]) begin
            st_d.c2.comparator_b_rw_select = wb_i.dat[`DTC_C2_BRW];
          end
        end
        `DTC_OFS_CMPA: st_d.ca = cmp_wr(st_q.ca, wb_i);
        `DTC_OFS_CMPB: st_d.cb = cmp_wr(st_q.cb, wb_i);
        `DTC_OFS_CMPC: st_d.cc = cmp_wr(st_q.cc, wb_i);
        default: ;
      endcase
    end

    // register reads
    rd_d = '0;
    case (wb_i.adr)
      `DTC_OFS_CTRL1: begin
        rd_d[`DTC_C1_EN]     = st_q.c1.trace_mode_enable;
        rd_d[`DTC_C1_ARM]    = st_q.armed;
        rd_d[`DTC_C1_TRIGGER_SELECT] = st_q.c1.trigger_select;
        rd_d[`DTC_C1_BEGIN]  = st_q.c1.begin_trig;
        rd_d[`DTC_C1_CAP]    = st_q.c1.capture;
        rd_d[`DTC_C1_BRK]    = st_q.c1.brk_en;
        rd_d[`DTC_C1_MODE]   = st_q.c1.mode;
      end
      `DTC_OFS_CTRL2: begin
        rd_d[`DTC_C2_LEG]   = st_q.c2.legacy_breakpoint_mode;
        rd_d[`DTC_C2_CEN]   = st_q.c2.third_breakpoint_enable;
        rd_d[`DTC_C2_CTAG]  = st_q.c2.third_breakpoint_tag_select;
        rd_d[`DTC_C2_CRWEN] = st_q.c2.third_breakpoint_rw_enable;
        rd_d[`DTC_C2_CRW]   = st_q.c2.third_breakpoint_rw_select;
        rd_d[`DTC_C2_ARWEN] = st_q.c2.comparator_a_rw_enable;
        rd_d[`DTC_C2_ARW]   = st_q.c2.comparator_a_rw_select;
        rd_d[`DTC_C2_BRWEN] = st_q.c2.comparator_b_rw_enable;
        rd_d[`DTC_C2_BRW]   = st_q.c2.comparator_b_rw_select;
      end
      `DTC_OFS_STAT: begin
        rd_d[`DTC_ST_FA]  = st_q.fa;
        rd_d[`DTC_ST_FB]  = st_q.fb;
        rd_d[`DTC_ST_FC]  = st_q.fc;
        rd_d[`DTC_ST_TRG] = st_q.trg;
        rd_d[`DTC_ST_CNT] = st_q.cnt;
      end
      `DTC_OFS_CMPA:  rd_d[`DTC_CMP_ALL] = st_q.ca;
      `DTC_OFS_CMPB:  rd_d[`DTC_CMP_ALL] = st_q.cb;
      `DTC_OFS_CMPC:  rd_d[`DTC_CMP_ALL] = st_q.cc;
      `DTC_OFS_TRACE: rd_d[`DTC_TRACE_DATA] = mem_rdata;
      default: ;
    endcase
    // trace read advances the read pointer
    if (req && !wb_i.we && (wb_i.adr == `DTC_OFS_TRACE) && !arm_wr) begin
      st_d.rp = st_q.rp + `DTC_PTR_ONE;
    end
    st_d.ack = req;
    if (req) begin
      st_d.dat = wb_i.we ? '0 : rd_d;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= DTC_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state
  assign ack_o     = st_q.ack;
  assign dat_o     = st_q.dat;
  assign trig_o    = st_q.trig;
  assign brk_req_o = st_q.brk;
  assign armed_o   = st_q.armed;

  property p_cnt_max;
    @(posedge clk_i) disable iff (rst_i) st_q.cnt <= `DTC_DEPTH;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("trace count above depth");

  property p_begin_full;
    @(posedge clk_i) disable iff (rst_i)
      (st_q.ts == TS_POST) && mem_we && (st_q.cnt == `DTC_LAST) && !arm_wr
      |=> !armed_o && (st_q.cnt == `DTC_DEPTH);
  endproperty
  a_begin_full: assert property (p_begin_full) else $error("begin not ended at full");

  property p_end_trig;
    @(posedge clk_i) disable iff (rst_i)
      (st_q.ts == TS_ARMED) && trig_c && !begin_eff && !arm_wr |=> !armed_o;
  endproperty
  a_end_trig: assert property (p_end_trig) else $error("arm kept after end trigger");

  property p_arm_clr;
    @(posedge clk_i) disable iff (rst_i)
      arm_wr && !set_a && !set_b && !set_c |=> !st_q.fa && !st_q.fb && !st_q.fc && armed_o;
  endproperty
  a_arm_clr: assert property (p_arm_clr) else $error("arming left flags set");

  property p_c_prio;
    @(posedge clk_i) disable iff (rst_i)
      eval && st_q.c1.trigger_select && (st_q.c1.mode == `DTC_M_AONLY) && c_t |=> !trig_o;
  endproperty
  a_c_prio: assert property (p_c_prio) else $error("tagged a beat tagged c");

  property p_full_rw;
    @(posedge clk_i) disable iff (rst_i)
      eval && !st_q.c1.trigger_select && (st_q.c1.mode == `DTC_M_AANDB)
      && st_q.c2.comparator_a_rw_enable && (core_i.rw != st_q.c2.comparator_a_rw_select)
      |=> !trig_o;
  endproperty
  a_full_rw: assert property (p_full_rw) else $error("full compare on wrong cycle");

  property p_full_hit;
    @(posedge clk_i) disable iff (rst_i)
      eval && !st_q.c1.trigger_select && (st_q.c1.mode == `DTC_M_AANDB) && a_f && b_eq
      |=> trig_o && st_q.fa && st_q.fb;
  endproperty
  a_full_hit: assert property (p_full_hit) else $error("a and b hit missed");

  property p_athb;
    @(posedge clk_i) disable iff (rst_i)
      eval && (st_q.c1.mode == `DTC_M_ATHB) && !st_q.seq |=> !trig_o;
  endproperty
  a_athb: assert property (p_athb) else $error("b fired before a");

  property p_evb;
    @(posedge clk_i) disable iff (rst_i)
      eval && !det && (st_q.c1.mode == `DTC_M_EVB) && b_f |=> trig_o && st_q.fb;
  endproperty
  a_evb: assert property (p_evb) else $error("event-only b missed");

  property p_brk;
    @(posedge clk_i) disable iff (rst_i)
      trig_o && $past(st_q.c1.brk_en) |-> brk_req_o;
  endproperty
  a_brk: assert property (p_brk) else $error("trigger without break request");

endmodule

//--- hw/dtc_regs.svh
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

// register byte offsets
`define DTC_OFS_CTRL1      8'h00
`define DTC_OFS_CTRL2      8'h04
`define DTC_OFS_STAT       8'h08
`define DTC_OFS_CMPA       8'h0C
`define DTC_OFS_CMPB       8'h10
`define DTC_OFS_CMPC       8'h14
`define DTC_OFS_TRACE      8'h18

// control one fields
`define DTC_C1_EN          0
`define DTC_C1_ARM         1
`define DTC_C1_TRIGGER_SELECT      2
`define DTC_C1_BEGIN       3
`define DTC_C1_CAP         5:4
`define DTC_C1_BRK         6
`define DTC_C1_MODE        11:8

// control two fields
`define DTC_C2_LEG         0
`define DTC_C2_CEN         1
`define DTC_C2_CTAG        2
`define DTC_C2_CRWEN       3
`define DTC_C2_CRW         4
`define DTC_C2_ARWEN       5
`define DTC_C2_ARW         6
`define DTC_C2_BRWEN       7
`define DTC_C2_BRW         8

// comparator word layout
`define DTC_CMP_ALL        23:0
`define DTC_PSEL_EXT_BIT   0

// status fields
`define DTC_ST_FA          0
`define DTC_ST_FB          1
`define DTC_ST_FC          2
`define DTC_ST_TRG         3
`define DTC_ST_CNT         14:8
`define DTC_TRACE_DATA     15:0

// byte lanes
`define DTC_LANE0          0
`define DTC_LANE1          1
`define DTC_LANE2          2
`define DTC_BYTE0          7:0
`define DTC_BYTE1          15:8
`define DTC_BYTE2          23:16

// trigger modes
`define DTC_M_AONLY        4'h0
`define DTC_M_AORB         4'h1
`define DTC_M_ATHB         4'h2
`define DTC_M_EVB          4'h3
`define DTC_M_AEVB         4'h4
`define DTC_M_AANDB        4'h5
`define DTC_M_ANOTB        4'h6

// capture modes
`define DTC_CAP_DETAIL     2'h2

// trace buffer sizing
`define DTC_DEPTH_N        64
`define DTC_DEPTH          7'h40
`define DTC_LAST           7'h3F
`define DTC_CNT_ONE        7'h01
`define DTC_PTR_ONE        6'h01

`endif

//--- hw/dtc_pkg.sv
package dtc_pkg;

  // trace sequencing states
  typedef enum logic [2:0] {
    TS_IDLE  = 3'b001,
    TS_ARMED = 3'b010,
    TS_POST  = 3'b100
  } dtc_tstate_t;

  // wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } dtc_wb_req_t;

  // watched core bus
  typedef struct packed {
    logic        valid;
    logic        rw;
    logic        fetch;
    logic        free;
    logic        cof;
    logic        exec;
    logic [5:0]  xaddr;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] exec_addr;
  } dtc_core_t;

  // comparator value, laid out as its register word
  typedef struct packed {
    logic [1:0]  page_selector;
    logic [5:0]  ext;
    logic [15:0] addr;
  } dtc_cmp_t;

  typedef struct packed {
    logic       trace_mode_enable;
    logic       trigger_select;
    logic       begin_trig;
    logic [1:0] capture;
    logic       brk_en;
    logic [3:0] mode;
  } dtc_ctrl1_t;

  typedef struct packed {
    logic legacy_breakpoint_mode;
    logic third_breakpoint_enable;
    logic third_breakpoint_tag_select;
    logic third_breakpoint_rw_enable;
    logic third_breakpoint_rw_select;
    logic comparator_a_rw_enable;
    logic comparator_a_rw_select;
    logic comparator_b_rw_enable;
    logic comparator_b_rw_select;
  } dtc_ctrl2_t;

  // whole state of the trigger block
  typedef struct packed {
    dtc_tstate_t ts;
    logic        armed;
    dtc_ctrl1_t  c1;
    dtc_ctrl2_t  c2;
    dtc_cmp_t    ca;
    dtc_cmp_t    cb;
    dtc_cmp_t    cc;
    logic        fa;
    logic        fb;
    logic        fc;
    logic        trg;
    logic        seq;
    logic [5:0]  wp;
    logic [5:0]  rp;
    logic [6:0]  cnt;
    logic        pend;
    logic [15:0] pdat;
    logic        ack;
    logic [31:0] dat;
    logic        brk;
    logic        trig;
  } dtc_state_t;

  localparam dtc_state_t DTC_RESET = '{ts: TS_IDLE, default: '0};

endpackage

//--- hw/dtc_trace_mem.sv
`timescale 1ns/1ps
`include "dtc_regs.svh"
module dtc_trace_mem (
  // clock
  input  logic        clk_i,
  // write port
  input  logic        we_i,
  input  logic [5:0]  waddr_i,
  input  logic [15:0] wdata_i,
  // read port
  input  logic [5:0]  raddr_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem_q [0:`DTC_DEPTH_N-1];

  // write and registered read
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule

//--- tb/dtc_core_model.sv
`timescale 1ns/1ps
module dtc_core_model (
  // clock
  input  wire logic          clk_i,
  // watched core bus
  output dtc_pkg::dtc_core_t core_o
);
  import dtc_pkg::*;

  // page bits shown with every bus cycle
  logic [5:0] page = '0;

  // quiet bus until the first cycle
  initial core_o = '0;

  // one bus cycle, then idle with the address lines flipped, and the data lines too after a write, so stale values never match
  task automatic cyc(input logic [15:0] a, input logic rw, input logic [15:0] d,
                     input logic cof, input logic ex);
    core_o <= '{valid: 1'b1, rw: rw, cof: cof, exec: ex, addr: a, exec_addr: a,
                wdata: rw ? ~d : d, rdata: rw ? d : ~d, xaddr: page, default: '0};
    @(posedge clk_i);
    core_o <= '{addr: ~a, exec_addr: ~a, wdata: ~d, rdata: d, default: '0};
    @(posedge clk_i);
  endtask
endmodule

//--- tb/debug_trigger_comparators_test.sv
`timescale 1ns/1ps
module debug_trigger_comparators_test;
  import dtc_pkg::*;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  dtc_wb_req_t wb_q  = '0;
  dtc_core_t   core;
  logic        ack_o;
  logic        trig_o;
  logic        brk_req_o;
  logic        armed_o;
  logic [31:0] dat_o;
  logic [31:0] r;
  int          num_errors = 0;
  int          n_checks   = 0;
  int          nt         = 0;
  int          nb         = 0;
  int          t0         = 0;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  dtc_trigger u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_q), .ack_o(ack_o),
    .dat_o(dat_o), .core_i(core), .trig_o(trig_o), .brk_req_o(brk_req_o),
    .armed_o(armed_o));
  dtc_core_model u_core (.clk_i(clk_i), .core_o(core));

  // count trigger and break pulses
  always @(posedge clk_i) begin
    if (trig_o === 1'b1) nt <= nt + 1;
    if (brk_req_o === 1'b1) nb <= nb + 1;
  end

  task automatic complete_run;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #125000;
    num_errors++;
    complete_run;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // classic wishbone single cycle, held until ack is seen
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_q <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
    // ack is read as sampled at each rising edge; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    r = dat_o;
    wb_q <= '0;
    @(posedge clk_i);
  endtask

  // software arms with enable and arm set
  task automatic arm(input logic [31:0] c2, input logic [31:0] c1);
    wb(8'h04, 1'b1, c2);
    wb(8'h00, 1'b1, c1);
    t0 = nt;
  endtask

  // status flags and trigger count since arming
  task automatic fin(input logic [3:0] st, input int trg);
    wb(8'h08, 1'b0, 32'h0);
    chk(32'(r[3:0]), 32'(st));
    chk(nt - t0, trg);
  endtask

  task automatic t_regs;
    chk(32'(armed_o), 32'h0);
    wb(8'h00, 1'b0, 32'h0);
    chk(r, 32'h0);
    wb(8'h0C, 1'b1, 32'h1234);
    wb(8'h10, 1'b1, 32'h5678);
    wb(8'h0C, 1'b0, 32'h0);
    chk(r, 32'h1234);
    wb(8'hFC, 1'b0, 32'h0);
    chk(r, 32'h0);
    $display("regs done");
  endtask

  task automatic t_modes;
    arm(32'h0, 32'h43);
    u_core.cyc(16'h5678, 1'b0, 16'h0, 1'b0, 1'b0);
    u_core.cyc(16'h1234, 1'b0, 16'h0, 1'b0, 1'b0);
    fin(4'h9, 1);
    chk(nb, 1);
    chk(32'(armed_o), 32'h0);
    arm(32'h0, 32'h143);
    u_core.cyc(16'h5678, 1'b0, 16'h0, 1'b0, 1'b0);
    fin(4'hA, 1);
    arm(32'h0, 32'h243);
    u_core.cyc(16'h5678, 1'b0, 16'h0, 1'b0, 1'b0);
    u_core.cyc(16'h1234, 1'b0, 16'h0, 1'b0, 1'b0);
    u_core.cyc(16'h5678, 1'b0, 16'h0, 1'b0, 1'b0);
    fin(4'hB, 1);
    $display("modes done");
  endtask

  task automatic t_full;
    arm(32'h0E0, 32'h543);
    u_core.cyc(16'h1234, 1'b0, 16'h5678, 1'b0, 1'b0);
    u_core.cyc(16'h1234, 1'b1, 16'h5678, 1'b0, 1'b0);
    fin(4'hB, 1);
    arm(32'h0, 32'h543);
    u_core.cyc(16'h1234, 1'b0, 16'h5678, 1'b0, 1'b0);
    fin(4'hB, 1);
    arm(32'h0E0, 32'h643);
    u_core.cyc(16'h1234, 1'b1, 16'h5678, 1'b0, 1'b0);
    u_core.cyc(16'h1234, 1'b1, 16'h0000, 1'b0, 1'b0);
    fin(4'hB, 1);
    $display("full done");
  endtask

  task automatic t_tag;
    arm(32'h020, 32'h47);
    u_core.cyc(16'h1234, 1'b1, 16'h0, 1'b0, 1'b0);
    u_core.cyc(16'h1234, 1'b1, 16'h0, 1'b0, 1'b1);
    fin(4'h9, 1);
    wb(8'h14, 1'b1, 32'h1234);
    arm(32'h006, 32'h47);
    u_core.cyc(16'h1234, 1'b1, 16'h0, 1'b0, 1'b1);
    fin(4'h4, 0);
    $display("tag done");
  endtask

  task automatic t_store;
    arm(32'h0, 32'h347);
    u_core.cyc(16'h5678, 1'b1, 16'hBEEF, 1'b0, 1'b0);
    fin(4'hA, 1);
    chk(32'(r[14:8]), 32'h1);
    chk(32'(armed_o), 32'h1);
    wb(8'h18, 1'b0, 32'h0);
    chk(32'(r[15:0]), 32'hBEEF);
    arm(32'h0, 32'h4B);
    u_core.cyc(16'h1234, 1'b0, 16'h0, 1'b1, 1'b0);
    for (int i = 0; i < 63; i++) u_core.cyc(16'h2000 + 16'(i), 1'b0, 16'h0, 1'b1, 1'b0);
    fin(4'h9, 1);
    chk(32'(r[14:8]), 32'h40);
    chk(32'(armed_o), 32'h0);
    wb(8'h18, 1'b0, 32'h0);
    chk(32'(r[15:0]), 32'h1234);
    arm(32'h0, 32'h43);
    for (int i = 0; i < 70; i++) u_core.cyc(16'h3000 + 16'(i), 1'b0, 16'h0, 1'b1, 1'b0);
    u_core.cyc(16'h1234, 1'b0, 16'h0, 1'b1, 1'b0);
    fin(4'h9, 1);
    chk(32'(r[14:8]), 32'h40);
    wb(8'h18, 1'b0, 32'h0);
    chk(32'(r[15:0]), 32'h3007);
    $display("store done");
  endtask

  task automatic t_event;
    arm(32'h0, 32'h443);
    u_core.cyc(16'h5678, 1'b1, 16'h1111, 1'b0, 1'b0);
    u_core.cyc(16'h1234, 1'b0, 16'h0, 1'b0, 1'b0);
    u_core.cyc(16'h5678, 1'b1, 16'hCAFE, 1'b0, 1'b0);
    u_core.cyc(16'h5678, 1'b1, 16'hF00D, 1'b0, 1'b0);
    fin(4'hB, 2);
    chk(32'(r[14:8]), 32'h2);
    chk(32'(armed_o), 32'h1);
    wb(8'h18, 1'b0, 32'h0);
    chk(32'(r[15:0]), 32'hCAFE);
    wb(8'h18, 1'b0, 32'h0);
    chk(32'(r[15:0]), 32'hF00D);
    arm(32'h0, 32'h323);
    u_core.cyc(16'h7000, 1'b0, 16'h00AA, 1'b0, 1'b0);
    u_core.cyc(16'h5678, 1'b1, 16'hBEEF, 1'b0, 1'b0);
    fin(4'hA, 1);
    chk(32'(r[14:8]), 32'h4);
    chk(32'(armed_o), 32'h0);
    wb(8'h18, 1'b0, 32'h0);
    chk(32'(r[15:0]), 32'h7000);
    wb(8'h18, 1'b0, 32'h0);
    chk(32'(r[15:0]), 32'h00AA);
    $display("event done");
  endtask

  task automatic t_legacy;
    int b0;
    b0 = nb;
    wb(8'h04, 1'b1, 32'h3);
    u_core.cyc(16'h1234, 1'b0, 16'h0, 1'b0, 1'b0);
    wb(8'h08, 1'b0, 32'h0);
    chk(32'(r[2]), 32'h1);
    chk(nb - b0, 1);
    wb(8'h0C, 1'b1, 32'h00451234);
    arm(32'h0, 32'h43);
    u_core.cyc(16'h1234, 1'b0, 16'h0, 1'b0, 1'b0);
    u_core.page = 6'h05;
    u_core.cyc(16'h1234, 1'b0, 16'h0, 1'b0, 1'b0);
    fin(4'h9, 1);
    $display("legacy done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_modes;
    t_full;
    t_tag;
    t_store;
    t_event;
    t_legacy;
    complete_run;
  end
endmodule
